// ---- core/io_status_pkg.sv ----
// Constants for the completion status unit: codes, register map, timing
package io_status_pkg;
  // Completion codes written into byte 1 of the parameter block
  localparam logic [7:0] CC_SUCCESS       = 8'h00;
  localparam logic [7:0] CC_BAD_LUN       = 8'h11;
  localparam logic [7:0] CC_MODE_ERR      = 8'h12;
  localparam logic [7:0] CC_BAD_CMD       = 8'h14;
  localparam logic [7:0] CC_SG_LENGTH     = 8'h1c;
  localparam logic [7:0] CC_NEXT_ALIGN    = 8'h1e;
  localparam logic [7:0] CC_SG_ALIGN      = 8'h1f;
  localparam logic [7:0] CC_DISCARD_ADDR  = 8'h21;
  localparam logic [7:0] CC_BAD_PRIORITY  = 8'h22;
  localparam logic [7:0] CC_COUNT_SIZE    = 8'h23;
  localparam logic [7:0] CC_RESEL_TMO     = 8'h41;
  localparam logic [7:0] CC_SELECT_TMO    = 8'h42;
  localparam logic [7:0] CC_OP_TMO        = 8'h43;
  localparam logic [7:0] CC_DMA_TMO       = 8'h44;
  localparam logic [7:0] CC_ODD_RESUME    = 8'h45;
  localparam logic [7:0] CC_FIFO_PARITY   = 8'h46;
  localparam logic [7:0] CC_BUS_ERROR     = 8'h4b;
  localparam logic [7:0] CC_RESIDUAL      = 8'h62;
  localparam logic [7:0] CC_PHASE_CHANGE  = 8'h73;
  localparam logic [7:0] CC_SYNC_REQ      = 8'h74;
  localparam logic [7:0] CC_MSG_REJECT    = 8'h75;
  localparam logic [7:0] CC_REQ_STUCK     = 8'h76;
  localparam logic [7:0] CC_DATA_AFTER_0  = 8'h77;
  localparam logic [7:0] CC_ABORTED       = 8'h83;

  // Limits
  localparam logic [3:0]  MAX_LUN         = 4'h7;
  localparam logic [31:0] MAX_DMA_BYTES   = 32'h0100_0000;  // 16 megabytes
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SEL_TMO_MS      = 250;
  localparam int unsigned OP_TMO_MS       = 2000;
  localparam int unsigned DMA_TMO_MS      = 1;
  localparam int unsigned SEL_TMO_CYC     = SEL_TMO_MS * (CLK_HZ / 1000);
  localparam int unsigned OP_TMO_CYC      = OP_TMO_MS * (CLK_HZ / 1000);
  localparam int unsigned DMA_TMO_CYC     = DMA_TMO_MS * (CLK_HZ / 1000);

  // Wishbone register word addresses (byte address bits 3:2)
  localparam logic [1:0] REG_STATUS       = 2'h0;  // Code, flags, sense key view
  localparam logic [1:0] REG_CONTROL      = 2'h1;  // DMA and operation timer disable, abort clear
  localparam logic [1:0] REG_SENSE        = 2'h2;  // Last sense byte 2
  localparam logic [1:0] REG_ABORT        = 2'h3;  // Pending abort map with targets 4-7 ORed onto targets 0-3

  // Field positions in the status register
  localparam int CODE_LSB    = 0;
  localparam int DONE_BIT    = 8;
  localparam int ERROR_SUMMARY_FLAG_BIT    = 9;
  localparam int FATAL_BIT   = 10;
  localparam int KEY_LSB     = 12;

  // Control register reset value: timers enabled
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // Sense key encoding
  typedef enum logic [3:0] {
    KEY_NONE = 4'h0, KEY_RECOVERED = 4'h1, KEY_NOT_READY = 4'h2, KEY_MEDIUM = 4'h3,
    KEY_HARDWARE = 4'h4, KEY_ILLEGAL = 4'h5, KEY_ATTENTION = 4'h6, KEY_PROTECT = 4'h7,
    KEY_BLANK = 4'h8, KEY_VENDOR = 4'h9, KEY_COPY_ABORT = 4'ha, KEY_ABORTED = 4'hb,
    KEY_EQUAL = 4'hc, KEY_OVERFLOW = 4'hd, KEY_MISCOMPARE = 4'he, KEY_RESERVED = 4'hf
  } sense_key_e;
endpackage

// ---- core/io_completion_status_unit.sv ----
// Completion status unit: classifies parameter block outcome and reports it
//
// How it works
// [R1] Code goes to block byte 1; valid only with done; no reserved code made.
// [R2] Clean block reports code 00.
// [R3] Logical unit above seven rejects with code 11.
// [R4] Invalid command code ends block with code 14.
// [R5] Odd next-block address gives 1e and stops the chain.
// [R6] Odd scatter/gather address gives 1f.
// [R7] Scatter/gather word total mismatch gives 1c.
// [R8] Misaligned discard transfer address in word or longword mode gives 21.
// [R9] Priority block other than request sense or controller gives 22.
// [R10] DMA count above 16 megabytes gives 23.
// [R11] Reselection timeout gives 41.
// [R12] Selection unanswered for 250 ms gives 42.
// [R13] Block unfinished after two seconds gives 43.
// [R14] DMA engine unfinished within 1 ms gives 44.
// [R15] Odd resume address with byte swap gives 45.
// [R16] Bus error as master gives 4b; FIFO parity error gives 46.
// [R17] Moved and requested byte counts differ at end gives 62.
// [R18] Phase change 73, stuck request 76, data after count zero 77.
// [R19] Bad sync answer 74, rejected valid message 75.
// [R20] After check condition abort later nonzero-level blocks with 83 until sense or test unit ready.
// [R21] Sense key decoded per standard table, F reserved.
// [R22] Target puts information at bytes 03-06 MSB first, length at 07.
// [R23] Error summary for block failures, fatal flag for reset-needing failures.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module io_completion_status_unit
  import io_status_pkg::*;
#(
  parameter int unsigned SEL_TMO = io_status_pkg::SEL_TMO_CYC,
  parameter int unsigned OP_TMO  = io_status_pkg::OP_TMO_CYC,
  parameter int unsigned DMA_TMO = io_status_pkg::DMA_TMO_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Block start and static checks from the command engine
  input  wire logic        blk_start_i,
  input  wire logic [3:0]  blk_lun_i,
  input  wire logic [2:0]  blk_target_i,
  input  wire logic        blk_int_nonzero_i,
  input  wire logic        blk_is_sense_i,
  input  wire logic        blk_is_tur_i,
  input  wire logic        blk_is_ctrl_i,
  input  wire logic        blk_priority_i,
  input  wire logic        blk_cmd_valid_i,
  input  wire logic [31:0] blk_dma_count_i,
  input  wire logic        discard_transfer_i,
  input  wire logic        long_mode_i,
  input  wire logic [1:0]  data_addr_lo_i,
  input  wire logic        byte_swap_flag_i,
  // Runtime events, one-cycle pulses
  input  wire logic        next_addr_odd_i,
  input  wire logic        sg_addr_odd_i,
  input  wire logic        sg_len_bad_i,
  input  wire logic        resel_tmo_i,
  input  wire logic        sel_start_i,
  input  wire logic        sel_resp_i,
  input  wire logic        dma_start_i,
  input  wire logic        dma_done_i,
  input  wire logic        resume_odd_i,
  input  wire logic        bus_err_i,
  input  wire logic        fifo_parity_i,
  input  wire logic        phase_err_i,
  input  wire logic        req_stuck_i,
  input  wire logic        data_after_zero_i,
  input  wire logic        sync_bad_i,
  input  wire logic        msg_reject_i,
  input  wire logic        fatal_i,
  input  wire logic        check_cond_i,
  input  wire logic [7:0]  sense_byte2_i,
  input  wire logic        sense_valid_i,
  // Transfer end with counts
  input  wire logic        xfer_end_i,
  input  wire logic [31:0] dma_moved_i,
  // Completion write-back toward the block in memory
  output logic             done_o,
  output logic [7:0]       code_o,
  output logic             error_summary_flag_o,
  output logic             fatal_error_flag_o,
  output logic             stop_chain_o,
  output logic [3:0]       sense_key_o
);
  import io_status_pkg::*;

  // Elaboration check: a zero count would wrap the limit to all ones and stall a watchdog
  if (SEL_TMO < 1 || OP_TMO < 1 || DMA_TMO < 1) begin
    $error("Timeout counts must be positive");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_e;

  typedef struct packed {
    state_e      st;
    logic [31:0] op_cnt;
    logic [31:0] sel_cnt;
    logic [31:0] dma_cnt;
    logic        sel_on;
    logic        dma_on;
    logic [7:0]  code;
    logic        done;
    logic        error_summary_flag;
    logic        fatal;
    logic        stop_chain;
    logic [3:0]  key;
    logic [7:0]  sense2;
    logic [63:0] abort_map;
    logic [1:0]  ctrl;
    logic [31:0] rdat;
    logic        ack;
  } state_s;

  state_s q, d;

  // Priority picker over runtime faults; last listed wins
  function automatic logic [7:0] runtime_code();
    logic [7:0] c;
    c = CC_SUCCESS;
    if (msg_reject_i)      c = CC_MSG_REJECT;     // R19
    if (sync_bad_i)        c = CC_SYNC_REQ;       // R19
    if (data_after_zero_i) c = CC_DATA_AFTER_0;   // R18
    if (req_stuck_i)       c = CC_REQ_STUCK;      // R18
    if (phase_err_i)       c = CC_PHASE_CHANGE;   // R18
    if (fifo_parity_i)     c = CC_FIFO_PARITY;    // R16
    if (bus_err_i)         c = CC_BUS_ERROR;      // R16
    if (resume_odd_i && byte_swap_flag_i) c = CC_ODD_RESUME;  // R15
    if (resel_tmo_i)       c = CC_RESEL_TMO;      // R11
    if (sg_len_bad_i)      c = CC_SG_LENGTH;      // R7
    if (sg_addr_odd_i)     c = CC_SG_ALIGN;       // R6
    if (next_addr_odd_i)   c = CC_NEXT_ALIGN;     // R5
    return c;
  endfunction

  logic [5:0] tl_idx;
  logic [7:0] rt_code;
  logic       disc_bad;
  logic       wb_hit;

  // Next-state logic
  always_comb begin
    d = q;
    d.ack = 1'b0;
    tl_idx = {blk_target_i, blk_lun_i[2:0]};
    rt_code = runtime_code();
    disc_bad = long_mode_i ? (data_addr_lo_i != 2'h0) : data_addr_lo_i[0];  // R8
    wb_hit = wb_cyc_i && wb_stb_i && !q.ack;

    unique case (q.st)
      ST_IDLE: begin
        if (blk_start_i) begin
          d.done = 1'b0;
          d.error_summary_flag = 1'b0;
          d.stop_chain = 1'b0;
          d.op_cnt = '0;
          d.sel_on = 1'b0;
          d.dma_on = 1'b0;
          d.code = CC_SUCCESS;
          // Static checks finish the block at once, in a fixed priority
          if (blk_lun_i > MAX_LUN) d.code = CC_BAD_LUN;                 // R3
          else if (blk_priority_i && !blk_is_sense_i && !blk_is_ctrl_i)
            d.code = CC_BAD_PRIORITY;                                    // R9
          else if (!blk_cmd_valid_i) d.code = CC_BAD_CMD;               // R4
          else if (blk_dma_count_i > MAX_DMA_BYTES) d.code = CC_COUNT_SIZE;  // R10
          else if (discard_transfer_i && disc_bad) d.code = CC_DISCARD_ADDR;  // R8
          else if (q.abort_map[tl_idx] && blk_int_nonzero_i
                   && !blk_is_sense_i && !blk_is_tur_i) d.code = CC_ABORTED;  // R20
          if (d.code != CC_SUCCESS) begin
            d.done = 1'b1;  // R1
            d.error_summary_flag = 1'b1;  // R23
          end else begin
            if (blk_is_sense_i || blk_is_tur_i) d.abort_map[tl_idx] = 1'b0;  // R20
            d.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        d.op_cnt = q.op_cnt + 32'd1;
        // Selection and DMA watchdogs
        if (sel_start_i) begin
          d.sel_on = 1'b1;
          d.sel_cnt = '0;
        end else if (sel_resp_i) d.sel_on = 1'b0;
        else if (q.sel_on) d.sel_cnt = q.sel_cnt + 32'd1;
        if (dma_start_i) begin
          d.dma_on = 1'b1;
          d.dma_cnt = '0;
        end else if (dma_done_i) d.dma_on = 1'b0;
        else if (q.dma_on) d.dma_cnt = q.dma_cnt + 32'd1;

        if (fatal_i) begin
          d.fatal = 1'b1;  // R23
          d.done = 1'b1;
          d.st = ST_IDLE;
        end else if (rt_code != CC_SUCCESS) begin
          d.code = rt_code;
          d.stop_chain = next_addr_odd_i;  // R5
        end else if (q.sel_on && q.sel_cnt >= SEL_TMO - 1) begin
          d.code = CC_SELECT_TMO;  // R12
        end else if (q.dma_on && q.dma_cnt >= DMA_TMO - 1 && !q.ctrl[0]) begin
          d.code = CC_DMA_TMO;  // R14
        end else if (q.op_cnt >= OP_TMO - 1 && !q.ctrl[0]) begin
          d.code = CC_OP_TMO;  // R13
        end else if (xfer_end_i) begin
          d.code = (dma_moved_i != blk_dma_count_i) ? CC_RESIDUAL : CC_SUCCESS;  // R17 R2
        end
        if (!fatal_i && (d.code != CC_SUCCESS || xfer_end_i)) begin
          d.done = 1'b1;  // R1
          d.error_summary_flag = (d.code != CC_SUCCESS);  // R23
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // Sense key capture from extended sense byte 2
    if (sense_valid_i) begin
      d.sense2 = sense_byte2_i;
      d.key = sense_byte2_i[3:0];  // R21
    end

    // Wishbone slave, answers one cycle after the request
    if (wb_hit) begin
      d.ack = 1'b1;
      d.rdat = '0;
      if (wb_we_i) begin
        if (wb_adr_i[3:2] == REG_CONTROL && wb_sel_i[0]) begin
          d.ctrl = wb_dat_i[1:0];
          if (wb_dat_i[1]) d.abort_map = '0;
          d.ctrl[1] = 1'b0;
        end
      end else begin
        unique case (wb_adr_i[3:2])
          REG_STATUS:  d.rdat = {16'h0, q.key, 1'b0, q.fatal, q.error_summary_flag, q.done, q.code};
          REG_CONTROL: d.rdat = {30'h0, q.ctrl};
          REG_SENSE:   d.rdat = {24'h0, q.sense2};
          REG_ABORT:   d.rdat = q.abort_map[31:0] | q.abort_map[63:32];
        endcase
      end
    end

    // Sticky abort set comes last: a check condition beats a bus clear in one cycle
    if (check_cond_i && q.st == ST_RUN) begin
      d.abort_map[tl_idx] = 1'b1;  // R20
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl <= CONTROL_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign done_o               = q.done;
  assign code_o               = q.code;
  assign error_summary_flag_o = q.error_summary_flag;
  assign fatal_error_flag_o   = q.fatal;
  assign stop_chain_o         = q.stop_chain;
  assign sense_key_o          = q.key;
  assign wb_dat_o             = q.rdat;
  assign wb_ack_o             = q.ack;

  // Assertions
  chk_lun_reject: assert property (@(posedge clk_i) disable iff (rst_i)  // R3
    (q.st == ST_IDLE && blk_start_i && blk_lun_i > MAX_LUN)
      |=> (done_o && code_o == CC_BAD_LUN && error_summary_flag_o))
    else $error("Bad logical unit not rejected with 11");
  chk_success_code: assert property (@(posedge clk_i) disable iff (rst_i)  // R2
    (done_o && !error_summary_flag_o && !fatal_error_flag_o) |-> code_o == CC_SUCCESS)
    else $error("Clean completion without code 00");
  chk_count_size: assert property (@(posedge clk_i) disable iff (rst_i)  // R10
    (q.st == ST_IDLE && blk_start_i && blk_lun_i <= MAX_LUN && !blk_priority_i
     && blk_cmd_valid_i && blk_dma_count_i > MAX_DMA_BYTES) |=> code_o == CC_COUNT_SIZE)
    else $error("Oversized count not reported");
  chk_next_stop: assert property (@(posedge clk_i) disable iff (rst_i)  // R5
    (q.st == ST_RUN && next_addr_odd_i && !fatal_i)
      |=> (stop_chain_o && code_o == CC_NEXT_ALIGN && done_o))
    else $error("Misaligned next block not stopped");
  chk_residual: assert property (@(posedge clk_i) disable iff (rst_i)  // R17
    (q.st == ST_RUN && xfer_end_i && !fatal_i && rt_code == CC_SUCCESS
     && !(q.sel_on && q.sel_cnt >= SEL_TMO - 1) && !(q.dma_on && q.dma_cnt >= DMA_TMO - 1)
     && q.op_cnt < OP_TMO - 1 && dma_moved_i != blk_dma_count_i)
      |=> code_o == CC_RESIDUAL)
    else $error("Residual mismatch not reported");
  chk_bus_error: assert property (@(posedge clk_i) disable iff (rst_i)  // R16
    (q.st == ST_RUN && bus_err_i && !fatal_i && !next_addr_odd_i && !sg_addr_odd_i
     && !sg_len_bad_i && !resel_tmo_i && !(resume_odd_i && byte_swap_flag_i))
      |=> code_o == CC_BUS_ERROR)
    else $error("Bus error not reported as 4b");
  chk_abort_set: assert property (@(posedge clk_i) disable iff (rst_i)  // R20
    (q.st == ST_RUN && check_cond_i) |=> q.abort_map[$past(tl_idx)])
    else $error("Check condition did not arm abort");
  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not one cycle after request");
  chk_done_error_summary_flag: assert property (@(posedge clk_i) disable iff (rst_i)  // R23
    (done_o && code_o != CC_SUCCESS) |-> error_summary_flag_o)
    else $error("Error code without error summary");
endmodule

// ---- testbench/far_side_model.sv ----
// Far-side model: command engine and target events, extended sense frame
`timescale 1ns/1ps
module far_side_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Requests from the bench
  input  wire logic        fire_i,
  input  wire logic [4:0]  ev_sel_i,
  input  wire logic        sense_req_i,
  input  wire logic [3:0]  key_i,
  // Toward the status unit
  output logic      [18:0] ev_o,
  output logic             sense_valid_o,
  output logic      [7:0]  sense_byte2_o
);
  typedef struct packed {
    logic [18:0] ev;
    logic        valid;
    logic [7:0]  byte2;
    logic [31:0] info;
    logic [7:0]  len;
  } model_s;
  model_s st_q;
  model_s st_d;
  // One-cycle event pulses; the sense frame is rebuilt on each request
  always_comb begin
    st_d       = st_q;
    st_d.ev    = fire_i ? (19'h1 << ev_sel_i) : 19'h0;
    st_d.valid = sense_req_i;
    if (sense_req_i) begin
      st_d.byte2 = {4'h0, key_i};
      st_d.info  = 32'h0000_0100;
      st_d.len   = 8'h0a;
    end
  end
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign ev_o          = st_q.ev;
  assign sense_valid_o = st_q.valid;
  // Byte lane is not held after the pulse: show the inverse so stale data cannot match
  assign sense_byte2_o = st_q.valid ? st_q.byte2 : ~st_q.byte2;
endmodule

// ---- testbench/io_completion_status_unit_tb.sv ----
// Self-checking bench for the completion status unit
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module io_completion_status_unit_tb;
  import io_status_pkg::*;
  typedef struct {
    logic [3:0] lun; logic pri; logic ctl; logic cmdv; logic [31:0] cnt; logic disc;
    logic lng; logic [1:0] lo; int ev; logic [31:0] moved; logic [7:0] code;
  } row_s;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf, blk_lun_i = 4'h0, key = 4'h0;
  logic [31:0] wb_dat_i = '0, blk_dma_count_i = '0, dma_moved_i = '0, rd;
  logic        blk_start_i = 1'b0, blk_int_nonzero_i = 1'b0, blk_is_sense_i = 1'b0;
  logic        blk_is_tur_i = 1'b0, blk_is_ctrl_i = 1'b0, blk_priority_i = 1'b0;
  logic        blk_cmd_valid_i = 1'b1, discard_transfer_i = 1'b0, long_mode_i = 1'b0;
  logic        byte_swap_flag_i = 1'b1, fire_q = 1'b0, sense_req = 1'b0;
  logic [2:0]  blk_target_i = 3'h0;
  logic [1:0]  data_addr_lo_i = 2'h0;
  logic [4:0]  ev_sel = 5'h0;
  logic [18:0] ev;
  logic [31:0] wb_dat_o;
  logic [7:0]  code_o, sense_byte2_i;
  logic [3:0]  sense_key_o;
  logic        wb_ack_o, done_o, error_summary_flag_o, fatal_error_flag_o, stop_chain_o;
  logic        sense_valid_i, next_addr_odd_i, sg_addr_odd_i, sg_len_bad_i, resel_tmo_i;
  logic        resume_odd_i, bus_err_i, fifo_parity_i, phase_err_i, req_stuck_i, sync_bad_i;
  logic        data_after_zero_i, msg_reject_i, check_cond_i, sel_start_i, sel_resp_i;
  logic        dma_start_i, dma_done_i, fatal_i, xfer_end_i;
  logic [7:0]  ev_code [12] = '{CC_NEXT_ALIGN, CC_SG_ALIGN, CC_SG_LENGTH, CC_RESEL_TMO,
    CC_ODD_RESUME, CC_BUS_ERROR, CC_FIFO_PARITY, CC_PHASE_CHANGE, CC_REQ_STUCK,
    CC_DATA_AFTER_0, CC_SYNC_REQ, CC_MSG_REJECT};
  row_s        rows[$];
  row_s        ok;
  int          cycles = 0, mismatches = 0, n_compared = 0;

  // Event vector order is fixed by the far-side model's select codes
  assign {xfer_end_i, fatal_i, dma_done_i, dma_start_i, sel_resp_i, sel_start_i, check_cond_i,
          msg_reject_i, sync_bad_i, data_after_zero_i, req_stuck_i, phase_err_i,
          fifo_parity_i, bus_err_i, resume_odd_i, resel_tmo_i, sg_len_bad_i, sg_addr_odd_i,
          next_addr_odd_i} = ev;

  // Short timer parameters keep the timeout cases within a few hundred cycles
  io_completion_status_unit #(.SEL_TMO(20), .OP_TMO(200), .DMA_TMO(10))
    io_completion_status_unit_inst (.*);
  far_side_model far_side_model_inst (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire_q),
    .ev_sel_i(ev_sel), .sense_req_i(sense_req), .key_i(key), .ev_o(ev),
    .sense_valid_o(sense_valid_i), .sense_byte2_o(sense_byte2_i));

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic note(input string name);
    $display("test %s done", name);
  endtask

  // Classic single cycle; waits as long as the slave needs
  task automatic wb(input logic we, input logic [1:0] reg_w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {reg_w, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // Ack and read data are taken at the rising edge where ack is seen high
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic fire(input int k);
    @(posedge clk_i);
    ev_sel <= k[4:0];
    fire_q <= 1'b1;
    @(posedge clk_i);
    fire_q <= 1'b0;
  endtask

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    @(negedge clk_i);
    while (done_o !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic begin_row(input row_s r);
    @(posedge clk_i);
    blk_lun_i          <= r.lun;
    blk_priority_i     <= r.pri;
    blk_is_ctrl_i      <= r.ctl;
    blk_cmd_valid_i    <= r.cmdv;
    blk_dma_count_i    <= r.cnt;
    discard_transfer_i <= r.disc;
    long_mode_i        <= r.lng;
    data_addr_lo_i     <= r.lo;
    dma_moved_i        <= r.moved;
    blk_start_i        <= 1'b1;
    @(posedge clk_i);
    blk_start_i <= 1'b0;
    if (r.ev != 31) begin
      fire(r.ev);
    end
  endtask

  initial begin
    ok = '{4'h0, 0, 0, 1, 32'h100, 0, 0, 2'h0, 18, 32'h100, CC_SUCCESS};
    rows.push_back('{4'h8, 0, 0, 1, 32'h100, 0, 0, 2'h0, 31, 32'h100, CC_BAD_LUN});
    rows.push_back('{4'h7, 1, 0, 1, 32'h100, 0, 0, 2'h0, 31, 32'h100, CC_BAD_PRIORITY});
    rows.push_back('{4'h7, 1, 1, 1, 32'h100, 0, 0, 2'h0, 18, 32'h100, CC_SUCCESS});
    rows.push_back('{4'h0, 0, 0, 0, 32'h100, 0, 0, 2'h0, 31, 32'h100, CC_BAD_CMD});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100_0001, 0, 0, 2'h0, 31, 32'h100, CC_COUNT_SIZE});
    rows.push_back('{4'h0, 0, 0, 1, MAX_DMA_BYTES, 0, 0, 2'h0, 18, MAX_DMA_BYTES, CC_SUCCESS});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 1, 0, 2'h1, 31, 32'h100, CC_DISCARD_ADDR});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 1, 1, 2'h2, 31, 32'h100, CC_DISCARD_ADDR});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 1, 1, 2'h0, 18, 32'h100, CC_SUCCESS});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 0, 0, 2'h0, 18, 32'hfe, CC_RESIDUAL});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 0, 0, 2'h0, 13, 32'h100, CC_SELECT_TMO});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 0, 0, 2'h0, 15, 32'h100, CC_DMA_TMO});
    rows.push_back('{4'h0, 0, 0, 1, 32'h100, 0, 0, 2'h0, 31, 32'h100, CC_OP_TMO});
    foreach (ev_code[i]) begin
      rows.push_back('{4'h0, 0, 0, 1, 32'h100, 0, 0, 2'h0, i, 32'h100, ev_code[i]});
    end
    // Reset values and the read-only status word
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({done_o, code_o, fatal_error_flag_o}, 10'h000)
    wb(1'b0, REG_CONTROL, 32'h0);
    `CHK(rd[1:0], CONTROL_RESET)
    wb(1'b1, REG_STATUS, 32'h0000_00ff);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[15:0], 16'h0000)
    note("reset");
    // Table of static checks, runtime faults and timeouts
    foreach (rows[i]) begin
      begin_row(rows[i]);
      wait_done(300);
      `CHK(code_o, rows[i].code)
      `CHK(error_summary_flag_o, rows[i].code != CC_SUCCESS)
      if (rows[i].code inside {CC_NEXT_ALIGN, CC_SUCCESS}) begin
        `CHK(stop_chain_o, rows[i].code == CC_NEXT_ALIGN)
      end
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[9:0], {rows[i].code != CC_SUCCESS, 1'b1, rows[i].code})
      note("row");
    end
    // DMA and operation timers disabled, then prompt answers keep a block running
    wb(1'b1, REG_CONTROL, 32'h1);
    ok.ev = 15;
    begin_row(ok);
    repeat (250) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(done_o, 1'b0)
    fire(18);
    wait_done(20);
    `CHK(code_o, CC_SUCCESS)
    wb(1'b1, REG_CONTROL, 32'h0);
    ok.ev = 13;
    begin_row(ok);
    fire(14);
    fire(15);
    fire(16);
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(done_o, 1'b0)
    fire(18);
    wait_done(20);
    `CHK(code_o, CC_SUCCESS)
    note("timers");
    // Check condition arms abort until a sense block arrives
    @(posedge clk_i);
    blk_target_i      <= 3'h3;
    blk_int_nonzero_i <= 1'b1;
    ok.ev = 12;
    begin_row(ok);
    fire(18);
    wait_done(20);
    ok.ev = 31;
    begin_row(ok);
    wait_done(20);
    `CHK(code_o, CC_ABORTED)
    @(posedge clk_i);
    blk_is_sense_i <= 1'b1;
    ok.ev = 18;
    begin_row(ok);
    wait_done(20);
    `CHK(code_o, CC_SUCCESS)
    @(posedge clk_i);
    blk_is_sense_i <= 1'b0;
    begin_row(ok);
    wait_done(20);
    `CHK(code_o, CC_SUCCESS)
    // Arm again, see the mark in the map, then clear it from the bus
    ok.ev = 12;
    begin_row(ok);
    fire(18);
    wait_done(20);
    wb(1'b0, REG_ABORT, 32'h0);
    `CHK(rd, 32'h0100_0000)
    wb(1'b1, REG_CONTROL, 32'h2);
    wb(1'b0, REG_ABORT, 32'h0);
    `CHK(rd, 32'h0000_0000)
    note("abort");
    // Every sense key value, through the port and the sense register
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      key       <= k[3:0];
      sense_req <= 1'b1;
      @(posedge clk_i);
      sense_req <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(sense_key_o, k[3:0])
      wb(1'b0, REG_SENSE, 32'h0);
      `CHK(rd[7:0], {4'h0, k[3:0]})
    end
    note("sense");
    // Fatal flag is sticky until reset
    ok.ev = 17;
    begin_row(ok);
    wait_done(20);
    `CHK({done_o, fatal_error_flag_o}, 2'b11)
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK(fatal_error_flag_o, 1'b0)
    note("fatal");
    final_report();
  end
endmodule
